// ==== shared/idedma_pkg.sv ====
// Notes on behaviour
// - Command bit 3 picks direction: 0 memory reads, 1 memory writes.
// - Command bit 0 enables the engine on 1 and disables it on 0.
// - Clearing enable halts for good; restart needs reprogramming and enable.
// - Clearing enable mid-transfer aborts and drops data taken from the drive.
// - Reserved bits read zero: command 2:1, status 4:3.
// - Status bit 7 is read-only: 1 means simplex mode, 0 independent.
// - Status bit 6 is a read-write drive 1 DMA capable flag.
// - Status bit 5 is a read-write drive 0 DMA capable flag.
// - Status bit 2 sets on a drive interrupt, cleared by writing 1.
// - Status bit 1 sets on a transfer error, cleared by writing 1.
// - Once enabled, transfer continues until every descriptor is done, a memory cycle fails or enable is cleared.
// - Each descriptor is fetched from memory when needed, never cached.
// - Word 1 holds a 16-bit byte count and end flag at bit 31; the code reads count bits 15:4 only.
// - On enable, fetch descriptor at table pointer and advance pointer by 08h.
// - After a descriptor with end flag, clear active and stop; else continue.
// - Status bit 0 is read-only, 1 while the engine is active.
// - Table pointer holds address in 31:2 and reads the next descriptor.
package idedma_pkg;

    localparam logic [7:0]  CMD_IDX    = 8'h08;
    localparam logic [7:0]  STAT_IDX   = 8'h0a;
    localparam logic [7:0]  PTR_IDX    = 8'h0c;
    localparam logic [11:0] CMD_ADDR   = {2'h0, CMD_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR  = {2'h0, STAT_IDX, 2'h0};
    localparam logic [11:0] PTR_ADDR   = {2'h0, PTR_IDX, 2'h0};

    localparam int unsigned CMD_EN     = 0;
    localparam int unsigned CMD_DIR    = 3;
    localparam int unsigned ST_ACT     = 0;
    localparam int unsigned ST_ERR     = 1;
    localparam int unsigned ST_IRQ     = 2;
    localparam int unsigned ST_D0      = 5;
    localparam int unsigned ST_D1      = 6;
    localparam int unsigned ST_SPX     = 7;
    localparam int unsigned END_OF_TABLE_BIT = 31;

    localparam logic [7:0]  CMD_RST    = 8'h00;
    localparam logic [7:0]  STAT_RST   = 8'h00;
    localparam logic [31:0] PTR_RST    = 32'h0000_0000;
    localparam logic [31:0] DESC_STEP  = 32'h0000_0008;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
    localparam logic [16:0] WORD_BYTES = 17'h0_0004;
    localparam logic [16:0] MAX_BYTES  = 17'h1_0000;

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH0, S_FETCH1, S_DRV_RD, S_MEM_WR, S_MEM_RD, S_DRV_WR
    } idedma_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } idedma_mreq_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } idedma_mrsp_t;

endpackage

// ==== hdl/idedma_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module idedma_top #(
    parameter logic SIMPLEX = 1'b0
) (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB register port
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Memory master port
    output idedma_pkg::idedma_mreq_t      mem_o,
    input  wire idedma_pkg::idedma_mrsp_t mem_i,
    // Drive pins
    input  wire logic                     drv_dreq,
    input  wire logic                     drv_intrq,
    input  wire logic [31:0]              drv_rdata,
    output logic                          drv_dack,
    output logic      [31:0]              drv_wdata
);

    idedma_pkg::idedma_state_t state;
    idedma_pkg::idedma_state_t next_state;

    logic [7:0]  cmd;
    logic [7:0]  next_cmd;
    logic        err;
    logic        next_err;
    logic        irq;
    logic        next_irq;
    logic [1:0]  cap;
    logic [1:0]  next_cap;
    logic [31:0] tbl_ptr;
    logic [31:0] next_tbl_ptr;
    logic [31:0] desc_addr;
    logic [31:0] next_desc_addr;
    logic [31:0] buf_addr;
    logic [31:0] next_buf_addr;
    logic [16:0] remain;
    logic [16:0] next_remain;
    logic        end_of_table_flag;
    logic        next_end_of_table_flag;
    logic [31:0] hold;
    logic [31:0] next_hold;
    logic [31:0] next_prdata;
    logic        next_pready;
    idedma_pkg::idedma_mreq_t next_mem;
    logic        next_dack;
    logic [31:0] next_wdata;

    // Pin synchronisers; stage 1 is read only by stage 2
    logic dreq_s1, dreq_s2;
    logic intrq_s1, intrq_s2, intrq_s3;

    logic active;
    logic apb_acc;
    logic wr_cmd;
    logic wr_stat;
    logic wr_ptr;
    logic start;
    logic last_word;
    logic mem_done;
    logic [7:0] stat_rd;

    assign active    = (state != idedma_pkg::S_IDLE);
    assign apb_acc   = psel & penable & pready;
    assign wr_cmd    = apb_acc & pwrite & (paddr == idedma_pkg::CMD_ADDR);
    assign wr_stat   = apb_acc & pwrite & (paddr == idedma_pkg::STAT_ADDR);
    assign wr_ptr    = apb_acc & pwrite & (paddr == idedma_pkg::PTR_ADDR);
    // Only a 0 to 1 write starts, so a halted run never resumes
    assign start     = wr_cmd & pwdata[idedma_pkg::CMD_EN]
                       & ~cmd[idedma_pkg::CMD_EN] & ~active;
    assign last_word = (remain <= idedma_pkg::WORD_BYTES);
    assign mem_done  = mem_o.req & mem_i.ack;

    always_comb begin
        stat_rd = 8'h00;
        stat_rd[idedma_pkg::ST_SPX] = SIMPLEX;
        stat_rd[idedma_pkg::ST_D1]  = cap[1];
        stat_rd[idedma_pkg::ST_D0]  = cap[0];
        stat_rd[idedma_pkg::ST_IRQ] = irq;
        stat_rd[idedma_pkg::ST_ERR] = err;
        stat_rd[idedma_pkg::ST_ACT] = active;
    end

    always_comb begin
        next_state     = state;
        next_cmd       = cmd;
        next_err       = err;
        next_irq       = irq;
        next_cap       = cap;
        next_tbl_ptr   = tbl_ptr;
        next_desc_addr = desc_addr;
        next_buf_addr  = buf_addr;
        next_remain    = remain;
        next_end_of_table_flag = end_of_table_flag;
        next_hold      = hold;
        next_mem       = mem_o;
        next_dack      = 1'b0;
        next_wdata     = drv_wdata;
        next_prdata    = prdata;
        // One wait state, so every access ends in exactly three cycles
        next_pready    = psel & penable & ~pready;

        if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
                idedma_pkg::CMD_ADDR:
                    next_prdata = {24'h0, 4'h0, cmd[idedma_pkg::CMD_DIR],
                                   2'h0, cmd[idedma_pkg::CMD_EN]};
                idedma_pkg::STAT_ADDR:
                    next_prdata = {24'h0, stat_rd};
                idedma_pkg::PTR_ADDR:
                    next_prdata = {tbl_ptr[31:2], 2'h0};
                default:
                    next_prdata = 32'h0;
            endcase
        end

        if (wr_cmd) begin
            next_cmd = 8'h00;
            next_cmd[idedma_pkg::CMD_DIR] = pwdata[idedma_pkg::CMD_DIR];
            next_cmd[idedma_pkg::CMD_EN]  = pwdata[idedma_pkg::CMD_EN];
        end
        if (wr_stat) begin
            next_cap = {pwdata[idedma_pkg::ST_D1], pwdata[idedma_pkg::ST_D0]};
            if (pwdata[idedma_pkg::ST_IRQ]) begin
                next_irq = 1'b0;
            end
            if (pwdata[idedma_pkg::ST_ERR]) begin
                next_err = 1'b0;
            end
        end
        if (wr_ptr) begin
            next_tbl_ptr = {pwdata[31:2], 2'h0};
        end
        // Sets come after clears so an event in the clearing cycle survives
        if (intrq_s2 & ~intrq_s3) begin
            next_irq = 1'b1;
        end

        case (state)
            idedma_pkg::S_IDLE: begin
                if (start) begin
                    next_desc_addr = tbl_ptr;
                    next_tbl_ptr   = tbl_ptr + idedma_pkg::DESC_STEP;
                    next_mem       = '{1'b1, 1'b0, tbl_ptr, 32'h0};
                    next_state     = idedma_pkg::S_FETCH0;
                end
            end
            idedma_pkg::S_FETCH0: begin
                if (mem_done) begin
                    next_buf_addr = {mem_i.rdata[31:4], 4'h0};
                    next_mem      = '{1'b1, 1'b0,
                                      desc_addr + idedma_pkg::WORD_STEP, 32'h0};
                    next_state    = idedma_pkg::S_FETCH1;
                end
            end
            idedma_pkg::S_FETCH1: begin
                if (mem_done) begin
                    next_mem.req = 1'b0;
                    next_end_of_table_flag =
                        mem_i.rdata[idedma_pkg::END_OF_TABLE_BIT];
                    // A zero count stands for a full 64 KB region
                    next_remain  = (mem_i.rdata[15:4] == 12'h0)
                                   ? idedma_pkg::MAX_BYTES
                                   : {1'b0, mem_i.rdata[15:4], 4'h0};
                    if (cmd[idedma_pkg::CMD_DIR]) begin
                        next_state = idedma_pkg::S_DRV_RD;
                    end else begin
                        next_mem   = '{1'b1, 1'b0, buf_addr, 32'h0};
                        next_state = idedma_pkg::S_MEM_RD;
                    end
                end
            end
            idedma_pkg::S_DRV_RD: begin
                if (dreq_s2 & ~drv_dack) begin
                    next_dack  = 1'b1;
                    next_hold  = drv_rdata;
                    next_mem   = '{1'b1, 1'b1, buf_addr, drv_rdata};
                    next_state = idedma_pkg::S_MEM_WR;
                end
            end
            idedma_pkg::S_MEM_RD: begin
                if (mem_done) begin
                    next_mem.req = 1'b0;
                    next_hold    = mem_i.rdata;
                    next_state   = idedma_pkg::S_DRV_WR;
                end
            end
            idedma_pkg::S_MEM_WR,
            idedma_pkg::S_DRV_WR: begin
                if ((state == idedma_pkg::S_MEM_WR) ? mem_done
                                                   : (dreq_s2 & ~drv_dack)) begin
                    next_mem.req  = 1'b0;
                    next_buf_addr = buf_addr + idedma_pkg::WORD_STEP;
                    next_remain   = remain - idedma_pkg::WORD_BYTES;
                    if (state == idedma_pkg::S_DRV_WR) begin
                        next_dack  = 1'b1;
                        next_wdata = hold;
                    end
                    if (!last_word) begin
                        if (cmd[idedma_pkg::CMD_DIR]) begin
                            next_state = idedma_pkg::S_DRV_RD;
                        end else begin
                            next_mem   = '{1'b1, 1'b0,
                                           buf_addr + idedma_pkg::WORD_STEP,
                                           32'h0};
                            next_state = idedma_pkg::S_MEM_RD;
                        end
                    end else if (end_of_table_flag) begin
                        next_state = idedma_pkg::S_IDLE;
                    end else begin
                        next_desc_addr = tbl_ptr;
                        next_tbl_ptr   = tbl_ptr + idedma_pkg::DESC_STEP;
                        next_mem       = '{1'b1, 1'b0, tbl_ptr, 32'h0};
                        next_state     = idedma_pkg::S_FETCH0;
                    end
                end
            end
            default: begin
                next_state = idedma_pkg::S_IDLE;
            end
        endcase

        // A failed memory cycle ends the run with the error flag up
        if (mem_done & mem_i.err) begin
            next_err     = 1'b1;
            next_mem.req = 1'b0;
            next_state   = idedma_pkg::S_IDLE;
        end
        // Abort: word held from the drive is dropped, no more memory cycles
        if (active & ~next_cmd[idedma_pkg::CMD_EN]) begin
            next_hold    = 32'h0;
            next_mem.req = 1'b0;
            next_dack    = 1'b0;
            next_state   = idedma_pkg::S_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dreq_s1   <= 1'b0;
            dreq_s2   <= 1'b0;
            intrq_s1  <= 1'b0;
            intrq_s2  <= 1'b0;
            intrq_s3  <= 1'b0;
            state     <= idedma_pkg::S_IDLE;
            cmd       <= idedma_pkg::CMD_RST;
            err       <= idedma_pkg::STAT_RST[idedma_pkg::ST_ERR];
            irq       <= idedma_pkg::STAT_RST[idedma_pkg::ST_IRQ];
            cap       <= idedma_pkg::STAT_RST[idedma_pkg::ST_D1:idedma_pkg::ST_D0];
            tbl_ptr   <= idedma_pkg::PTR_RST;
            desc_addr <= 32'h0;
            buf_addr  <= 32'h0;
            remain    <= 17'h0;
            end_of_table_flag <= 1'b0;
            hold      <= 32'h0;
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            mem_o     <= '0;
            drv_dack  <= 1'b0;
            drv_wdata <= 32'h0;
        end else begin
            dreq_s1   <= drv_dreq;
            dreq_s2   <= dreq_s1;
            intrq_s1  <= drv_intrq;
            intrq_s2  <= intrq_s1;
            intrq_s3  <= intrq_s2;
            state     <= next_state;
            cmd       <= next_cmd;
            err       <= next_err;
            irq       <= next_irq;
            cap       <= next_cap;
            tbl_ptr   <= next_tbl_ptr;
            desc_addr <= next_desc_addr;
            buf_addr  <= next_buf_addr;
            remain    <= next_remain;
            end_of_table_flag <= next_end_of_table_flag;
            hold      <= next_hold;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= 1'b0;
            mem_o     <= next_mem;
            drv_dack  <= next_dack;
            drv_wdata <= next_wdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dir_write;
        mem_o.req && mem_o.we |-> cmd[idedma_pkg::CMD_DIR];
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("memory write issued with read direction");

    property p_enable_start;
        start |=> active ##0 mem_o.req ##0 (mem_o.addr == $past(tbl_ptr));
    endproperty
    a_enable_start: assert property (p_enable_start)
        else $error("enable did not start a descriptor fetch");

    property p_abort;
        active && wr_cmd && !pwdata[idedma_pkg::CMD_EN]
            |=> !active && !mem_o.req && hold == 32'h0;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort left the engine running");

    property p_reserved;
        pready && !pwrite && paddr == idedma_pkg::STAT_ADDR
            |-> prdata[4:3] == 2'h0 && prdata[7] == SIMPLEX
                && prdata[31:8] == 24'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("status reserved or simplex bits wrong");

    property p_irq_set;
        intrq_s2 && !intrq_s3 |=> irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("drive interrupt not recorded");

    property p_err_stop;
        mem_done && mem_i.err |=> err && !active;
    endproperty
    a_err_stop: assert property (p_err_stop)
        else $error("memory error not reported");

    property p_ptr_step;
        start |=> tbl_ptr == $past(tbl_ptr) + idedma_pkg::DESC_STEP;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("table pointer not advanced by eight");

    property p_table_end_stop;
        (state == idedma_pkg::S_MEM_WR) && mem_done && !mem_i.err
            && last_word && end_of_table_flag |=> !active ##1 !active;
    endproperty
    a_table_end_stop: assert property (p_table_end_stop)
        else $error("engine ran past the last descriptor");

    property p_fetch_addr;
        state == idedma_pkg::S_FETCH1 && mem_o.req
            |-> mem_o.addr == desc_addr + idedma_pkg::WORD_STEP;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("second descriptor word fetched from wrong address");

endmodule // idedma_top
`default_nettype wire

// ==== tb/idedma_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module idedma_partner (
    // Clock
    input  wire logic                     pclk,
    // Memory side
    input  wire idedma_pkg::idedma_mreq_t mem_o,
    output var idedma_pkg::idedma_mrsp_t  mem_i,
    input  wire logic [7:0]               lat,
    input  wire logic [31:0]              err_addr,
    // Drive side
    input  wire logic                     dreq_on,
    input  wire logic [31:0]              drv_base,
    input  wire logic                     drv_dack,
    input  wire logic [31:0]              drv_wdata,
    output logic                          drv_dreq,
    output logic [31:0]                   drv_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] got [$];
    logic [7:0]  cnt;
    logic [31:0] idx;

    initial begin
        mem_i = '0;
        cnt = 8'h00;
        idx = 32'h0;
        drv_dreq = 1'b0;
        drv_rdata = 32'h0;
    end

    // Read data toggles outside an answer so a stale word never looks valid
    always @(posedge pclk) begin
        mem_i.ack <= 1'b0;
        mem_i.err <= 1'b0;
        mem_i.rdata <= ~mem_i.rdata;
        if (!mem_o.req || mem_i.ack) begin
            cnt <= 8'h00;
        end else if (cnt < lat) begin
            cnt <= cnt + 8'h01;
        end else begin
            cnt <= 8'h00;
            mem_i.ack <= 1'b1;
            mem_i.err <= (mem_o.addr === err_addr);
            if (mem_o.we) begin
                mem[mem_o.addr] = mem_o.wdata;
            end else if (mem.exists(mem_o.addr)) begin
                mem_i.rdata <= mem[mem_o.addr];
            end
        end
    end

    // Drive keeps the next word valid while it requests
    always @(posedge pclk) begin
        drv_dreq <= dreq_on;
        idx <= !dreq_on ? 32'h0 : idx + {31'h0, drv_dack};
        drv_rdata <= dreq_on ? drv_base + idx + {31'h0, drv_dack} : ~drv_rdata;
        if (drv_dack) begin
            got.push_back(drv_wdata);
        end
    end
endmodule // idedma_partner
`default_nettype wire

// ==== tb/ide_bus_master_dma_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module ide_bus_master_dma_bench;
    localparam logic [11:0] CMD  = idedma_pkg::CMD_ADDR;
    localparam logic [11:0] STAT = idedma_pkg::STAT_ADDR;
    localparam logic [11:0] PTR  = idedma_pkg::PTR_ADDR;
    logic                     pclk, presetn, psel, penable, pwrite;
    logic                     pready, pslverr, drv_intrq, drv_dreq;
    logic                     drv_dack, dreq_on;
    logic                     rd_err;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rd_data, drv_rdata;
    logic [31:0]              drv_wdata, drv_base, err_addr;
    logic [7:0]               lat;
    idedma_pkg::idedma_mreq_t mem_o;
    idedma_pkg::idedma_mrsp_t mem_i;
    int                       num_errors = 0;
    int                       n_tests = 0;
    int                       i;
    int                       k;

    idedma_top #(.SIMPLEX(1'b0)) i_idedma_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i),
        .drv_dreq(drv_dreq), .drv_intrq(drv_intrq), .drv_rdata(drv_rdata),
        .drv_dack(drv_dack), .drv_wdata(drv_wdata));

    idedma_partner i_idedma_partner (
        .pclk(pclk), .mem_o(mem_o), .mem_i(mem_i), .lat(lat),
        .err_addr(err_addr), .dreq_on(dreq_on), .drv_base(drv_base),
        .drv_dack(drv_dack), .drv_wdata(drv_wdata), .drv_dreq(drv_dreq),
        .drv_rdata(drv_rdata));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("Mismatches %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic bail;
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish;
    endtask

    // One transfer, then one idle cycle so psel is never assigned twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 20) bail();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_data, e)
    endtask

    task automatic wait_idle;
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, STAT, 32'h0);
            if (rd_data[0] === 1'b0) break;
        end
        if (n == 300) bail();
    endtask

    task automatic put(input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] w);
        i_idedma_partner.mem[a] = b;
        i_idedma_partner.mem[a + 32'h4] = w;
    endtask

    task automatic start(input logic [31:0] tbl, input logic dir);
        wr(PTR, tbl);
        wr(STAT, 32'h06);
        wr(CMD, {28'h0, dir, 3'b000});
        wr(CMD, {28'h0, dir, 3'b001});
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        drv_intrq = 1'b0;
        dreq_on = 1'b0;
        drv_base = 32'h0;
        err_addr = 32'hffff_fff0;
        lat = 8'd3;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CMD, 32'h00);
        rd(STAT, 32'h00);
        rd(PTR, 32'h00);
        rd(12'h3fc, 32'h00);
        `CHK(rd_err, 1'b0)
        wr(CMD, 32'hf6);
        rd(CMD, 32'h00);
        wr(CMD, 32'h0e);
        rd(CMD, 32'h08);
        wr(STAT, 32'hff);
        rd(STAT, 32'h60);
        wr(STAT, 32'h40);
        rd(STAT, 32'h40);
        wr(STAT, 32'h20);
        rd(STAT, 32'h20);
        wr(STAT, 32'h00);
        wr(PTR, 32'h0000_1237);
        rd(PTR, 32'h0000_1234);
        drv_intrq <= 1'b1;
        repeat (4) @(posedge pclk);
        drv_intrq <= 1'b0;
        rd(STAT, 32'h04);
        wr(STAT, 32'h04);
        rd(STAT, 32'h00);
        // Reads toward the drive across two descriptors
        put(32'h100, 32'h400, 32'h0000_0010);
        put(32'h108, 32'h800, 32'h8000_0010);
        for (i = 0; i < 8; i++) begin
            i_idedma_partner.mem[(i < 4 ? 32'h400 : 32'h7f0) + 32'(4 * i)] =
                32'ha5a5_0000 + 32'(i);
        end
        dreq_on <= 1'b1;
        start(32'h100, 1'b0);
        rd(STAT, 32'h01);
        rd(PTR, 32'h108);
        wait_idle();
        rd(PTR, 32'h110);
        `CHK(32'(i_idedma_partner.got.size()), 32'd8)
        for (i = 0; i < 8; i++) begin
            `CHK(i_idedma_partner.got[i], 32'ha5a5_0000 + 32'(i))
        end
        // Same table with the end flag moved up: must be fetched afresh
        i_idedma_partner.mem[32'h104] = 32'h8000_0010;
        i_idedma_partner.got.delete();
        start(32'h100, 1'b0);
        wait_idle();
        `CHK(32'(i_idedma_partner.got.size()), 32'd4)
        rd(PTR, 32'h108);
        dreq_on <= 1'b0;
        wr(CMD, 32'h00);
        // Writes to memory from the drive
        put(32'h200, 32'hc00, 32'h8000_0010);
        drv_base <= 32'h3c3c_0000;
        dreq_on <= 1'b1;
        start(32'h200, 1'b1);
        wait_idle();
        for (i = 0; i < 4; i++) begin
            `CHK(i_idedma_partner.mem[32'hc00 + 32'(4 * i)], 32'h3c3c_0000 + 32'(i))
        end
        dreq_on <= 1'b0;
        wr(CMD, 32'h00);
        // Memory error in mid-buffer
        put(32'h300, 32'h400, 32'h8000_0010);
        err_addr <= 32'h408;
        dreq_on <= 1'b1;
        start(32'h300, 1'b0);
        wait_idle();
        rd(STAT, 32'h02);
        wr(STAT, 32'h02);
        rd(STAT, 32'h00);
        dreq_on <= 1'b0;
        wr(CMD, 32'h00);
        // Abort while a memory write waits on a slow answer
        lat <= 8'd20;
        put(32'h380, 32'he00, 32'h8000_0010);
        i_idedma_partner.mem[32'he00] = 32'h0bad_0bad;
        drv_base <= 32'h7777_0000;
        dreq_on <= 1'b1;
        start(32'h380, 1'b1);
        for (k = 0; k < 300; k++) begin
            @(posedge pclk);
            if (mem_o.req === 1'b1 && mem_o.we === 1'b1) break;
        end
        if (k == 300) bail();
        wr(CMD, 32'h08);
        repeat (2) @(posedge pclk);
        `CHK(mem_o.req, 1'b0)
        rd(STAT, 32'h00);
        repeat (30) @(posedge pclk);
        `CHK(i_idedma_partner.mem[32'he00], 32'h0bad_0bad)
        `CHK(mem_o.req, 1'b0)
        dreq_on <= 1'b0;
        wr(CMD, 32'h00);
        tally_and_finish();
    end
endmodule // ide_bus_master_dma_bench
`default_nettype wire
